// >>> dv/disk_misc_command_executor_bench.sv
// self-checking bench joining the host and drive ends
`timescale 1ns/100ps
`default_nettype none
module disk_misc_command_executor_bench;
	// short counts keep the run brief
	localparam int SEEK_N = 4;
	localparam int DIAG_N = 6;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        reqValid = 1'b0;
	logic [7:0]  reqCode = 8'h00;
	logic [7:0]  reqFeatures = 8'h00;
	logic [7:0]  reqCount = 8'h00;
	logic [7:0]  reqSector = 8'h00;
	logic [15:0] reqCylinder = 16'h0000;
	logic [3:0]  reqHead = 4'h0;
	logic        reqLba = 1'b0;
	logic [15:0] reqData = 16'h0000;
	logic        isFirstDrive = 1'b1;
	logic        romOk = 1'b1;
	logic        ramOk = 1'b1;
	logic        regOk = 1'b1;
	logic        slaveDiagOk = 1'b1;
	logic        slavePresent = 1'b1;
	logic        reqReady, reqRejected, doneValid, doneErr, ucodeSaved;
	logic [7:0]  doneErrReg, logSpt;
	logic [3:0]  logHeadsM1;
	int          err_count = 0;
	int          checks = 0;
	int          wordCnt = 0;
	int          strobeCnt = 0;
	int          w0, s0;
	logic [5:0]  diagIn [7] = '{6'h3f, 6'h37, 6'h3b, 6'h3d, 6'h3e, 6'h1e, 6'h2e};
	logic [7:0]  diagExp [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h81, 8'h01, 8'h01};
	logic [7:0]  factOps [9] = '{8'h80, 8'h8f, 8'h9a, 8'hf0, 8'hf7, 8'hfa, 8'hfb, 8'hfc, 8'hff};

	dmce_if tfLink ();
	dmce_device #(.SEEK_CYCLES(SEEK_N), .DIAG_CYCLES(DIAG_N)) i_dmce_device (
		.sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1), .tf(tfLink),
		.romOk(romOk), .ramOk(ramOk), .regOk(regOk), .isFirstDrive(isFirstDrive),
		.slavePresent(slavePresent), .slaveDiagOk(slaveDiagOk),
		.logHeadsM1(logHeadsM1), .logSpt(logSpt), .ucodeSaved(ucodeSaved));
	dmce_host i_dmce_host (
		.sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1), .reqValid(reqValid), .reqCode(reqCode),
		.reqFeatures(reqFeatures), .reqCount(reqCount), .reqSector(reqSector),
		.reqCylinder(reqCylinder), .reqHead(reqHead), .reqDrive(1'b0), .reqLba(reqLba),
		.reqData(reqData), .reqReady(reqReady), .reqRejected(reqRejected),
		.doneValid(doneValid), .doneErr(doneErr), .doneErrReg(doneErrReg), .tf(tfLink));
	dmce_link_properties #(.SEEK_CYCLES(SEEK_N), .DIAG_CYCLES(DIAG_N)) i_props (
		.sys_clk(sys_clk), .rstn(rstn), .cmdStrobe(tfLink.cmdStrobe), .cmdCode(tfLink.cmdCode),
		.featuresReg(tfLink.featuresReg), .sectorCountReg(tfLink.sectorCountReg),
		.sectorNumberReg(tfLink.sectorNumberReg), .lbaMode(tfLink.lbaMode),
		.dataValid(tfLink.dataValid), .busy(tfLink.busy), .dataReq(tfLink.dataReq),
		.seekComplete(tfLink.seekComplete), .errFlag(tfLink.errFlag),
		.errorReg(tfLink.errorReg), .hostIrq(tfLink.hostIrq));

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) reqData <= reqData + 16'h0001;
	always @(posedge sys_clk) if (tfLink.dataValid) wordCnt <= wordCnt + 1;
	always @(posedge sys_clk) if (tfLink.cmdStrobe) strobeCnt <= strobeCnt + 1;

	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		checks++;
		if (seen !== expv)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic issue(input logic [7:0] code, feat, cnt, sec, input logic [15:0] cyl,
		input logic [3:0] head, input logic lba);
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 2000)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 2000)
			err_count++;
		@(posedge sys_clk);
		reqValid <= 1'b1;
		{reqCode, reqFeatures, reqCount, reqSector} <= {code, feat, cnt, sec};
		{reqCylinder, reqHead, reqLba} <= {cyl, head, lba};
		@(posedge sys_clk);
		reqValid <= 1'b0;
	endtask

	// a command the drive answers; error flag only judged where it is defined
	task automatic do_cmd(input logic [7:0] code, feat, cnt, sec, input logic [15:0] cyl,
		input logic [3:0] head, input logic lba, input logic [7:0] expReg, input logic chkFlag);
		int n;
		n = 0;
		issue(code, feat, cnt, sec, cyl, head, lba);
		while (doneValid !== 1'b1 && n < 2000)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 2000)
			err_count++;
		check(doneErrReg, expReg);
		if (chkFlag)
			check(doneErr, expReg != 8'h00);
	endtask

	initial
	begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		check({4'h0, logHeadsM1, logSpt}, 16'h0f3f);
		for (int c = 0; c < 16; c++)
			do_cmd(8'h70 | 8'(c), 8'h00, 8'h00, 8'h01, 16'h0000, 4'h0, 1'b1, 8'h00, 1'b1);
		check(tfLink.seekComplete, 1'b1);
		do_cmd(8'h91, 8'h00, 8'h01, 8'h10, 16'hffff, 4'h3, 1'b0, 8'h00, 1'b1);
		check({4'h0, logHeadsM1, logSpt}, 16'h0310);
		do_cmd(8'h91, 8'h00, 8'h00, 8'h20, 16'h0000, 4'h1, 1'b0, 8'h04, 1'b1);
		do_cmd(8'h91, 8'h00, 8'h01, 8'h40, 16'h0000, 4'h1, 1'b0, 8'h04, 1'b1);
		check({4'h0, logHeadsM1, logSpt}, 16'h0310);
		do_cmd(8'h70, 8'h00, 8'h00, 8'h01, 16'h0005, 4'h4, 1'b0, 8'h10, 1'b1);
		do_cmd(8'h70, 8'h00, 8'h00, 8'h11, 16'h0005, 4'h3, 1'b0, 8'h10, 1'b1);
		do_cmd(8'h70, 8'h00, 8'h00, 8'h00, 16'h0005, 4'h3, 1'b0, 8'h10, 1'b1);
		do_cmd(8'h70, 8'h00, 8'h00, 8'h10, 16'h0005, 4'h3, 1'b0, 8'h00, 1'b1);
		do_cmd(8'h91, 8'h00, 8'h01, 8'h3f, 16'h0000, 4'hf, 1'b0, 8'h00, 1'b1);
		do_cmd(8'h7f, 8'h00, 8'h00, 8'h3f, 16'hffff, 4'hf, 1'b0, 8'h10, 1'b1);
		do_cmd(8'h7f, 8'h00, 8'h00, 8'h3f, 16'hffff, 4'hf, 1'b1, 8'h00, 1'b1);
		for (int d = 0; d < 7; d++)
		begin
			@(posedge sys_clk);
			{isFirstDrive, slavePresent, romOk, ramOk, regOk, slaveDiagOk} <= diagIn[d];
			do_cmd(8'h90, 8'h00, 8'h01, 8'h01, 16'h0000, 4'h0, 1'b0, diagExp[d], 1'b0);
		end
		w0 = wordCnt;
		do_cmd(8'h92, 8'h05, 8'h01, 8'h00, 16'h0000, 4'h0, 1'b0, 8'h04, 1'b1);
		check(ucodeSaved, 1'b0);
		do_cmd(8'h92, 8'h07, 8'h00, 8'h00, 16'h0000, 4'h0, 1'b0, 8'h00, 1'b1);
		check(ucodeSaved, 1'b1);
		check(16'(wordCnt - w0), 16'h0000);
		do_cmd(8'h92, 8'h07, 8'h02, 8'h00, 16'h0000, 4'h0, 1'b0, 8'h00, 1'b1);
		check(16'(wordCnt - w0), 16'h0200);
		s0 = strobeCnt;
		for (int f = 0; f < 9; f++)
		begin
			issue(factOps[f], 8'h00, 8'h00, 8'h00, 16'h0000, 4'h0, 1'b0);
			@(negedge sys_clk);
			check(reqRejected, 1'b1);
		end
		check(16'(strobeCnt - s0), 16'h0000);
		print_verdict();
	end

	// whole run needs under two thousand cycles, well inside the 20000-cycle limit
	initial
	begin
		#(20 * 20000);
		err_count++;
		print_verdict();
	end
endmodule // disk_misc_command_executor_bench
`default_nettype wire

// >>> dv/dmce_link_properties.sv
// concurrent checks on the task-file link between host and drive
`timescale 1ns/100ps
`default_nettype none
module dmce_link_properties #(
	parameter int SEEK_CYCLES = 16,
	parameter int DIAG_CYCLES = 8
) (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       rstn,
	// host to drive
	input wire logic       cmdStrobe,
	input wire logic [7:0] cmdCode,
	input wire logic [7:0] featuresReg,
	input wire logic [7:0] sectorCountReg,
	input wire logic [7:0] sectorNumberReg,
	input wire logic       lbaMode,
	input wire logic       dataValid,
	// drive to host
	input wire logic       busy,
	input wire logic       dataReq,
	input wire logic       seekComplete,
	input wire logic       errFlag,
	input wire logic [7:0] errorReg,
	input wire logic       hostIrq
);
	localparam int SEEK_IRQ = SEEK_CYCLES + 1;
	localparam int DIAG_IRQ = DIAG_CYCLES + 1;
	logic take;
	// strobes while busy are dropped by the drive, so only idle ones count
	assign take = cmdStrobe && !busy && !dataReq;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_seek_starts: assert property (take && cmdCode[7:4] == 4'h7 && lbaMode |=> busy && !seekComplete)
		else $error("seek did not start");
	a_seek_done_time: assert property (take && cmdCode[7:4] == 4'h7 && lbaMode
		|-> ##SEEK_IRQ hostIrq && !busy && seekComplete)
		else $error("seek completion late or early");
	a_busy_fall_irq: assert property ($fell(busy) |-> hostIrq)
		else $error("busy dropped without interrupt");
	a_idnf_no_move: assert property (hostIrq && errorReg == 8'h10 |-> !$past(busy))
		else $error("id-not-found after positioning");
	a_diag_result: assert property (take && cmdCode == 8'h90 |-> ##DIAG_IRQ hostIrq
		&& errorReg[6:0] != 7'h00 && errorReg[6:0] < 7'h05)
		else $error("diagnostics result missing");
	a_irq_one_cycle: assert property (hostIrq |=> !hostIrq)
		else $error("interrupt longer than one cycle");
	a_geom_immediate: assert property (take && cmdCode == 8'h91 |=> hostIrq && !busy)
		else $error("geometry command not immediate");
	a_geom_zero_abort: assert property (take && cmdCode == 8'h91 && sectorCountReg == 8'h00
		|=> errFlag && errorReg == 8'h04)
		else $error("zero sector count not aborted");
	a_ucode_reserved: assert property (take && cmdCode == 8'h92 && featuresReg != 8'h07
		|=> hostIrq && !dataReq && errorReg == 8'h04)
		else $error("reserved microcode action not aborted");
	a_ucode_zero: assert property (take && cmdCode == 8'h92 && featuresReg == 8'h07
		&& {sectorNumberReg, sectorCountReg} == 16'h0000 |=> hostIrq && !dataReq && !errFlag)
		else $error("zero-length microcode load asked for data");
	a_ucode_request: assert property (take && cmdCode == 8'h92 && featuresReg == 8'h07
		&& {sectorNumberReg, sectorCountReg} != 16'h0000 |=> dataReq && !hostIrq)
		else $error("microcode load did not request data");
	a_drq_end_irq: assert property ($fell(dataReq) |-> hostIrq && !errFlag)
		else $error("data request ended without completion");
	a_word_in_drq: assert property (dataValid |-> dataReq)
		else $error("microcode word outside data request");
	a_factory_blocked: assert property (cmdStrobe |-> cmdCode[7:4] != 4'h8
		&& !(cmdCode inside {8'h9a, 8'hf0, 8'hf7}) && cmdCode[7:1] != 7'h7d
		&& cmdCode[7:2] != 6'h3f)
		else $error("factory opcode reached the drive");

	c_seek: cover property (take && cmdCode[7:4] == 4'h7);
	c_diag: cover property (take && cmdCode == 8'h90);
	c_ucode: cover property ($fell(dataReq));
	c_geom_abort: cover property (take && cmdCode == 8'h91 && sectorCountReg == 8'h00);
endmodule // dmce_link_properties
`default_nettype wire

// >>> hdl/dmce_device.sv
// drive end: seek, diagnostics, geometry and microcode-load interpreter
`timescale 1ns/100ps
`default_nettype none
`include "dmce_defs.svh"
module dmce_device #(
	parameter int SEEK_CYCLES = `DMCE_SEEK_CYCLES,
	parameter int DIAG_CYCLES = `DMCE_DIAG_CYCLES
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic clkEn,
	// task-file link
	dmce_if.device    tf,
	// self-test results and drive identity
	input  wire logic romOk,
	input  wire logic ramOk,
	input  wire logic regOk,
	input  wire logic isFirstDrive,
	input  wire logic slavePresent,
	input  wire logic slaveDiagOk,
	// geometry readback for identify, microcode result
	output logic [3:0] logHeadsM1,
	output logic [7:0] logSpt,
	output logic       ucodeSaved
);
	// the 16-bit timer cannot count beyond these limits
	if (SEEK_CYCLES < 1 || SEEK_CYCLES > 65535 || DIAG_CYCLES < 1 || DIAG_CYCLES > 65535)
	begin : g_bad_counts
		$error("dmce_device: cycle counts out of range");
	end

	dmce_pkg::dmce_dev_state_t stateFf, nxtState;
	logic [15:0] timerFf, nxtTimer;
	logic [23:0] wordsFf, nxtWords;
	logic        busyFf, nxtBusy, drqFf, nxtDrq, dscFf, nxtDsc, errFf, nxtErr, irqFf, nxtIrq;
	logic [7:0]  errRegFf, nxtErrReg;
	logic [3:0]  headsFf, nxtHeads;
	logic [7:0]  sptFf, nxtSpt;
	logic        savedFf, nxtSaved;

	// chs check and translation against configured geometry
	logic        chsBad;
	logic [27:0] chsLba;
	logic [15:0] ucodeSecs;
	logic [7:0]  diagRes;
	always_comb begin
		chsLba = 28'((({12'h000, tf.cylinderReg} * (28'(headsFf) + 28'h0000001)
			+ 28'(tf.headReg)) * 28'(sptFf)) + 28'(tf.sectorNumberReg) - 28'h0000001);
		chsBad = (tf.headReg > headsFf) || (tf.sectorNumberReg == 8'h00)
			|| (tf.sectorNumberReg > sptFf);
		if (!chsBad && (chsLba > `DMCE_TOTAL_LBA))
			chsBad = 1'b1;
		if (tf.lbaMode)
			chsBad = 1'b0;
		ucodeSecs = {tf.sectorNumberReg, tf.sectorCountReg};
		diagRes = !romOk ? `DMCE_DIAG_FAIL_ROM : !ramOk ? `DMCE_DIAG_FAIL_RAM
			: !regOk ? `DMCE_DIAG_FAIL_REG : `DMCE_DIAG_PASS;
		// first drive folds in the second drive's verdict
		if (isFirstDrive && slavePresent && !slaveDiagOk)
			diagRes = diagRes | `DMCE_DIAG_SLAVE_BAD;
	end

	always_comb begin
		nxtState = stateFf;
		nxtTimer = timerFf;
		nxtWords = wordsFf;
		nxtBusy = busyFf;
		nxtDrq = drqFf;
		nxtDsc = dscFf;
		nxtErr = errFf;
		nxtIrq = 1'b0;
		nxtErrReg = errRegFf;
		nxtHeads = headsFf;
		nxtSpt = sptFf;
		nxtSaved = savedFf;
		case (stateFf)
			dmce_pkg::DEV_IDLE:
			begin
				if (tf.cmdStrobe)
				begin
					nxtErr = 1'b0;
					nxtErrReg = 8'h00;
					if (tf.cmdCode[7:4] == `DMCE_OPC_SEEK_HI)
					begin
						if (chsBad)
						begin
							nxtErr = 1'b1;
							nxtErrReg = `DMCE_ERR_IDNF;
							nxtIrq = 1'b1;
						end
						else
						begin
							// task file only read, never written back
							nxtBusy = 1'b1;
							nxtDsc = 1'b0;
							nxtTimer = 16'(SEEK_CYCLES);
							nxtState = dmce_pkg::DEV_SEEK;
						end
					end
					else if (tf.cmdCode == `DMCE_OPC_DIAG)
					begin
						nxtBusy = 1'b1;
						nxtTimer = 16'(DIAG_CYCLES);
						nxtState = dmce_pkg::DEV_DIAG;
					end
					else if (tf.cmdCode == `DMCE_OPC_GEOM)
					begin
						// cylinder register deliberately unused here
						if (tf.sectorCountReg == 8'h00 || tf.headReg > `DMCE_PHYS_HEADS
							|| tf.sectorNumberReg > `DMCE_PHYS_SPT)
						begin
							nxtErr = 1'b1;
							nxtErrReg = `DMCE_ERR_ABRT;
						end
						else
						begin
							nxtHeads = tf.headReg;
							nxtSpt = tf.sectorNumberReg;
						end
						nxtIrq = 1'b1;
					end
					else if (tf.cmdCode == `DMCE_OPC_UCODE)
					begin
						if (tf.featuresReg != `DMCE_UCODE_SAVE)
						begin
							nxtErr = 1'b1;
							nxtErrReg = `DMCE_ERR_ABRT;
							nxtIrq = 1'b1;
						end
						else if (ucodeSecs == 16'h0000)
						begin
							nxtSaved = 1'b1;
							nxtIrq = 1'b1;
						end
						else
						begin
							nxtWords = 24'(ucodeSecs) * 24'(`DMCE_WORDS_PER_SEC);
							nxtDrq = 1'b1;
							nxtState = dmce_pkg::DEV_XFER;
						end
					end
					else
					begin
						// factory and unknown opcodes are refused
						// data commands position on their own, never after a seek here
						nxtErr = 1'b1;
						nxtErrReg = `DMCE_ERR_ABRT;
						nxtIrq = 1'b1;
					end
				end
			end
			dmce_pkg::DEV_SEEK, dmce_pkg::DEV_DIAG:
			begin
				if (timerFf <= 16'h0001)
				begin
					nxtBusy = 1'b0;
					nxtIrq = 1'b1;
					if (stateFf == dmce_pkg::DEV_SEEK)
						nxtDsc = 1'b1;
					else
					begin
						nxtErrReg = diagRes;
						nxtDsc = 1'b1;
					end
					nxtState = dmce_pkg::DEV_IDLE;
				end
				else
					nxtTimer = timerFf - 16'h0001;
			end
			dmce_pkg::DEV_XFER:
			begin
				if (tf.dataValid)
				begin
					nxtWords = wordsFf - 24'h000001;
					if (wordsFf == 24'h000001)
					begin
						nxtDrq = 1'b0;
						nxtSaved = 1'b1;
						nxtIrq = 1'b1;
						nxtState = dmce_pkg::DEV_IDLE;
					end
				end
			end
			default:
				nxtState = dmce_pkg::DEV_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stateFf <= dmce_pkg::DEV_IDLE;
			timerFf <= 16'h0000;
			wordsFf <= 24'h000000;
			busyFf <= 1'b0;
			drqFf <= 1'b0;
			dscFf <= 1'b1;
			errFf <= 1'b0;
			irqFf <= 1'b0;
			errRegFf <= 8'h00;
			headsFf <= `DMCE_DEF_HEADS_M1;
			sptFf <= `DMCE_DEF_SPT;
			savedFf <= 1'b0;
		end
		else if (clkEn)
		begin
			stateFf <= nxtState;
			timerFf <= nxtTimer;
			wordsFf <= nxtWords;
			busyFf <= nxtBusy;
			drqFf <= nxtDrq;
			dscFf <= nxtDsc;
			errFf <= nxtErr;
			irqFf <= nxtIrq;
			errRegFf <= nxtErrReg;
			headsFf <= nxtHeads;
			sptFf <= nxtSpt;
			savedFf <= nxtSaved;
		end
	end

	assign tf.busy = busyFf;
	assign tf.dataReq = drqFf;
	assign tf.seekComplete = dscFf;
	assign tf.errFlag = errFf;
	assign tf.errorReg = errRegFf;
	assign tf.hostIrq = irqFf;
	assign logHeadsM1 = headsFf;
	assign logSpt = sptFf;
	assign ucodeSaved = savedFf;
endmodule // dmce_device
`default_nettype wire

// >>> hdl/dmce_host.sv
// host end: issues task-file commands and streams microcode words
`timescale 1ns/100ps
`default_nettype none
`include "dmce_defs.svh"
module dmce_host (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	input  wire logic clkEn,
	// user command request
	input  wire logic        reqValid,
	input  wire logic [7:0]  reqCode,
	input  wire logic [7:0]  reqFeatures,
	input  wire logic [7:0]  reqCount,
	input  wire logic [7:0]  reqSector,
	input  wire logic [15:0] reqCylinder,
	input  wire logic [3:0]  reqHead,
	input  wire logic        reqDrive,
	input  wire logic        reqLba,
	input  wire logic [15:0] reqData,
	// user answer
	output logic        reqReady,
	output logic        reqRejected,
	output logic        doneValid,
	output logic        doneErr,
	output logic [7:0]  doneErrReg,
	// task-file link
	dmce_if.host        tf
);
	dmce_pkg::dmce_hst_state_t stateFf, nxtState;
	logic        strobeFf, nxtStrobe, dvFf, nxtDv, rdyFf, nxtRdy, rejFf, nxtRej;
	logic        doneFf, nxtDone, dErrFf, nxtDErr;
	logic [7:0]  dErrRegFf, nxtDErrReg, codeFf, nxtCode, featFf, nxtFeat;
	logic [7:0]  cntFf, nxtCnt, secFf, nxtSec;
	logic [15:0] cylFf, nxtCyl, dataFf, nxtData;
	logic [3:0]  headFf, nxtHead;
	logic        drvFf, nxtDrv, lbaFf, nxtLba;
	logic        factory;

	always_comb begin
		factory = (reqCode[7:4] == `DMCE_OPC_FACT_HI) || (reqCode == `DMCE_OPC_FACT_9A)
			|| (reqCode == `DMCE_OPC_FACT_F0) || (reqCode == `DMCE_OPC_FACT_F7)
			|| (reqCode[7:1] == 7'h7d) || (reqCode[7:2] == 6'h3f);
		nxtState = stateFf;
		nxtStrobe = 1'b0;
		nxtDv = 1'b0;
		nxtRdy = rdyFf;
		nxtRej = 1'b0;
		nxtDone = 1'b0;
		nxtDErr = dErrFf;
		nxtDErrReg = dErrRegFf;
		nxtCode = codeFf;
		nxtFeat = featFf;
		nxtCnt = cntFf;
		nxtSec = secFf;
		nxtCyl = cylFf;
		nxtHead = headFf;
		nxtDrv = drvFf;
		nxtLba = lbaFf;
		nxtData = dataFf;
		case (stateFf)
			dmce_pkg::HST_IDLE:
			begin
				if (reqValid && rdyFf)
				begin
					if (factory)
						nxtRej = 1'b1;
					else
					begin
						// count split sn high / sc low for microcode
						nxtCode = reqCode;
						nxtFeat = reqFeatures;
						nxtCnt = reqCount;
						nxtSec = reqSector;
						nxtCyl = reqCylinder;
						nxtHead = reqHead;
						nxtDrv = reqDrive;
						nxtLba = reqLba;
						nxtStrobe = 1'b1;
						nxtRdy = 1'b0;
						nxtState = dmce_pkg::HST_WAIT;
					end
				end
			end
			dmce_pkg::HST_WAIT:
			begin
				// completion judged by irq only, not the legacy on-track bit
				if (tf.hostIrq)
				begin
					nxtDone = 1'b1;
					nxtDErr = tf.errFlag;
					nxtDErrReg = tf.errorReg;
					nxtRdy = 1'b1;
					nxtState = dmce_pkg::HST_IDLE;
				end
				else if (tf.dataReq)
					nxtState = dmce_pkg::HST_XFER;
			end
			dmce_pkg::HST_XFER:
			begin
				// the completion irq arrives while still here; missing it would hang
				if (tf.hostIrq)
				begin
					nxtDone = 1'b1;
					nxtDErr = tf.errFlag;
					nxtDErrReg = tf.errorReg;
					nxtRdy = 1'b1;
					nxtState = dmce_pkg::HST_IDLE;
				end
				// one word every other cycle while the drive asks; whole sectors
				else if (tf.dataReq && !dvFf)
				begin
					nxtDv = 1'b1;
					nxtData = reqData;
				end
				else if (!tf.dataReq)
					nxtState = dmce_pkg::HST_WAIT;
			end
			default:
				nxtState = dmce_pkg::HST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stateFf <= dmce_pkg::HST_IDLE;
			strobeFf <= 1'b0;
			dvFf <= 1'b0;
			rdyFf <= 1'b1;
			rejFf <= 1'b0;
			doneFf <= 1'b0;
			dErrFf <= 1'b0;
			dErrRegFf <= 8'h00;
			codeFf <= 8'h00;
			featFf <= 8'h00;
			cntFf <= 8'h00;
			secFf <= 8'h00;
			cylFf <= 16'h0000;
			headFf <= 4'h0;
			drvFf <= 1'b0;
			lbaFf <= 1'b0;
			dataFf <= 16'h0000;
		end
		else if (clkEn)
		begin
			stateFf <= nxtState;
			strobeFf <= nxtStrobe;
			dvFf <= nxtDv;
			rdyFf <= nxtRdy;
			rejFf <= nxtRej;
			doneFf <= nxtDone;
			dErrFf <= nxtDErr;
			dErrRegFf <= nxtDErrReg;
			codeFf <= nxtCode;
			featFf <= nxtFeat;
			cntFf <= nxtCnt;
			secFf <= nxtSec;
			cylFf <= nxtCyl;
			headFf <= nxtHead;
			drvFf <= nxtDrv;
			lbaFf <= nxtLba;
			dataFf <= nxtData;
		end
	end

	assign tf.cmdStrobe = strobeFf;
	assign tf.cmdCode = codeFf;
	assign tf.featuresReg = featFf;
	assign tf.sectorCountReg = cntFf;
	assign tf.sectorNumberReg = secFf;
	assign tf.cylinderReg = cylFf;
	assign tf.headReg = headFf;
	assign tf.driveSelectField = drvFf;
	assign tf.lbaMode = lbaFf;
	assign tf.dataValid = dvFf;
	assign tf.dataWord = dataFf;
	assign reqReady = rdyFf;
	assign reqRejected = rejFf;
	assign doneValid = doneFf;
	assign doneErr = dErrFf;
	assign doneErrReg = dErrRegFf;
endmodule // dmce_host
`default_nettype wire

// >>> inc/dmce_defs.svh
// constants for the misc command executor
`ifndef DMCE_DEFS_SVH
`define DMCE_DEFS_SVH
`define DMCE_OPC_SEEK_HI     4'h7
`define DMCE_OPC_FACT_HI     4'h8
`define DMCE_OPC_DIAG        8'h90
`define DMCE_OPC_GEOM        8'h91
`define DMCE_OPC_UCODE       8'h92
`define DMCE_OPC_FACT_9A     8'h9a
`define DMCE_OPC_FACT_F0     8'hf0
`define DMCE_OPC_FACT_F7     8'hf7
`define DMCE_UCODE_SAVE      8'h07
`define DMCE_SECTOR_BYTES    512
`define DMCE_WORDS_PER_SEC   16'h0100
`define DMCE_ERR_IDNF        8'h10
`define DMCE_ERR_ABRT        8'h04
`define DMCE_DIAG_PASS       8'h01
`define DMCE_DIAG_FAIL_ROM   8'h02
`define DMCE_DIAG_FAIL_RAM   8'h03
`define DMCE_DIAG_FAIL_REG   8'h04
`define DMCE_DIAG_SLAVE_BAD  8'h80
`define DMCE_SEEK_CYCLES     16
`define DMCE_DIAG_CYCLES     8
`define DMCE_PHYS_HEADS      4'hf
`define DMCE_PHYS_SPT        8'h3f
`define DMCE_TOTAL_LBA       28'h0ffffff
`define DMCE_DEF_HEADS_M1    4'hf
`define DMCE_DEF_SPT         8'h3f
`endif

// >>> inc/dmce_if.sv
// task-file link between host controller and drive
`timescale 1ns/100ps
`default_nettype none
interface dmce_if;
	logic        cmdStrobe;
	logic [7:0]  cmdCode;
	logic [7:0]  featuresReg;
	logic [7:0]  sectorCountReg;
	logic [7:0]  sectorNumberReg;
	logic [15:0] cylinderReg;
	logic [3:0]  headReg;
	logic        driveSelectField;
	logic        lbaMode;
	logic        dataValid;
	logic [15:0] dataWord;
	logic        busy;
	logic        dataReq;
	logic        seekComplete;
	logic        errFlag;
	logic [7:0]  errorReg;
	logic        hostIrq;
	modport device (
		input  cmdStrobe, cmdCode, featuresReg, sectorCountReg, sectorNumberReg,
		input  cylinderReg, headReg, driveSelectField, lbaMode, dataValid, dataWord,
		output busy, dataReq, seekComplete, errFlag, errorReg, hostIrq
	);
	modport host (
		output cmdStrobe, cmdCode, featuresReg, sectorCountReg, sectorNumberReg,
		output cylinderReg, headReg, driveSelectField, lbaMode, dataValid, dataWord,
		input  busy, dataReq, seekComplete, errFlag, errorReg, hostIrq
	);
endinterface
`default_nettype wire

// >>> inc/dmce_pkg.sv
// types of the misc command executor
package dmce_pkg;
	typedef enum logic [2:0] {
		DEV_IDLE,
		DEV_SEEK,
		DEV_DIAG,
		DEV_XFER,
		DEV_DONE
	} dmce_dev_state_t;
	typedef enum logic [1:0] {
		HST_IDLE,
		HST_WAIT,
		HST_XFER
	} dmce_hst_state_t;
endpackage
